//--- core/bsirq_core.sv
/*
  Strap capture and external interrupt conditioning.
  Boot and byte order straps are caught on the first edge after release and
  frozen; debug selects are followed every cycle; the interrupt inputs yield one-cycle edge pulses.
  Assumes every input is synchronous to ref_clk, that nrst is held low for
  at least one clock edge, and that boundary scan control lives outside.
*/
// Functional notes
// R1: Boot select 00 is emulation boot; 11 is reserved, board must avoid it.
// R2: Boot select 01, default, boots 8-bit async ROM in region one.
// R3: Boot select 10 boots 16-bit async ROM in region one.
// R4: Byte order input low selects big-endian operation.
// R5: Board holds bus big-order fix input low whenever big-endian is selected.
// R6: Boundary scan needs both debug selects low and reset driven low; scanMode decodes the selects alone and reads low during reset.
// R7: Rising edge on non-maskable input raises a non-maskable interrupt.
// R8: Board should ground an unused non-maskable input.
// R9: Four pins 4 to 7 act as edge interrupt inputs, still usable as GPIO.
// R10: Each interrupt pin's triggering edge chosen by its polarity bit [3:0].
// R11: Debug select 00 boundary scan, 11 emulation default; 01, 10 reserved.
// R12: Straps sampled during reset, held constant until the next reset; the code catches them on the first edge after release.
`timescale 1ns/100ps
`default_nettype none
`include "bsirq_regs.svh"

module bsirq_core
  import bsirq_pkg::*;
#(
  parameter int IRQ_PINS = `BSIRQ_IRQ_PINS
) (
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                nrst,
  // Straps
  input  wire logic [1:0]          bootSelect,
  input  wire logic                byteOrderSelect,
  input  wire logic                extBusBigOrderFix,
  input  wire logic [1:0]          debugModeSelect,
  // Interrupt inputs and polarity
  input  wire logic                nmiPin,
  input  wire logic [IRQ_PINS-1:0] extIrqPin,
  input  wire logic [IRQ_PINS-1:0] extIrqEdgePolarity,
  // Boot decode
  output var  logic                romBoot,
  output var  logic                emulBoot,
  output var  logic                romWidth16,
  output var  logic                bootFault,
  output var  logic [1:0]          bootSource,
  // Byte order
  output var  logic                bigEndian,
  output var  logic                orderFault,
  // Debug mode
  output var  logic                scanMode,
  output var  logic                emulMode,
  output var  logic                dbgFault,
  // Interrupt pulses
  output var  logic                nmiEvent,
  output var  logic [IRQ_PINS-1:0] extIrqEvent
);

  bsirq_state_s st;
  bsirq_state_s next_st;

  // Next state
  always_comb begin
    next_st = st;
    // Capture window: only the first edge after release, since the register is held in reset before it
    next_st.inReset = 1'h0;
    // Capture straps only on the first edge after reset release
    if (st.inReset) begin                                      // R12
      next_st.bootSel   = bootSelect;
      next_st.byteOrder = byteOrderSelect;
      next_st.orderFix  = extBusBigOrderFix;
    end
    next_st.dbgMode = debugModeSelect;
    // Boot decode
    next_st.emulBoot   = (next_st.bootSel == `BSIRQ_BOOT_EMUL);  // R1
    next_st.romBoot    = (next_st.bootSel == `BSIRQ_BOOT_ROM8) ||
                         (next_st.bootSel == `BSIRQ_BOOT_ROM16); // R2 R3
    next_st.romWidth16 = (next_st.bootSel == `BSIRQ_BOOT_ROM16)
                         ? `BSIRQ_WIDTH16 : `BSIRQ_WIDTH8;       // R3
    next_st.bootFault  = (next_st.bootSel == `BSIRQ_BOOT_RSVD);  // R1
    // Byte order and its companion pin check
    next_st.bigEndian  = (next_st.byteOrder == `BSIRQ_BIG_ORDER); // R4
    next_st.orderFault = next_st.bigEndian && next_st.orderFix;    // R5
    // Debug mode decode
    next_st.scanMode = (next_st.dbgMode == `BSIRQ_DBG_SCAN);       // R11
    next_st.emulMode = (next_st.dbgMode == `BSIRQ_DBG_EMUL);       // R11
    next_st.dbgFault = !next_st.scanMode && !next_st.emulMode;     // R11
    // Rising edge on the non-maskable input; history loads in the capture
    // window, so a pin resting at either level at release is no edge
    next_st.nmiLast  = nmiPin;
    next_st.nmiPulse = nmiPin && !st.nmiLast && !st.inReset;       // R7
    // Per-pin edge select: polarity high picks rising, low picks falling
    next_st.irqLast  = extIrqPin;
    next_st.irqPulse = ((extIrqPin & ~st.irqLast & extIrqEdgePolarity) |
                        (~extIrqPin & st.irqLast & ~extIrqEdgePolarity)) &
                       {IRQ_PINS{!st.inReset}};                      // R9 R10
  end

  // State register
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st           <= '0;
      st.inReset   <= 1'h1;
      st.bootSel   <= `BSIRQ_RST_BOOT;
      st.byteOrder <= `BSIRQ_RST_ORDER;
      st.orderFix  <= `BSIRQ_RST_FIX;
      st.romBoot   <= 1'h1;
      st.dbgMode   <= `BSIRQ_DBG_EMUL;
      st.emulMode  <= 1'h1;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from state
  assign romBoot     = st.romBoot;
  assign emulBoot    = st.emulBoot;
  assign romWidth16  = st.romWidth16;
  assign bootFault   = st.bootFault;
  assign bootSource  = st.bootSel;
  assign bigEndian   = st.bigEndian;
  assign orderFault  = st.orderFault;
  assign scanMode    = st.scanMode;
  assign emulMode    = st.emulMode;
  assign dbgFault    = st.dbgFault;
  assign nmiEvent    = st.nmiPulse;
  assign extIrqEvent = st.irqPulse;

  // Straps frozen after release
  property p_strap_hold;
    @(posedge ref_clk) disable iff (!nrst)
      !st.inReset |=> $stable(st.bootSel) && $stable(st.byteOrder) && $stable(st.orderFix);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap changed after reset"); // R12

  // The first edge after release decides what is shown afterwards
  property p_boot_capture;
    @(posedge ref_clk) disable iff (!nrst)
      st.inReset |=> (bootSource == $past(bootSelect));
  endproperty
  a_boot_capture: assert property (p_boot_capture) else $error("boot strap not captured"); // R12

  property p_order_capture;
    @(posedge ref_clk) disable iff (!nrst)
      st.inReset |=> (bigEndian == ($past(byteOrderSelect) == `BSIRQ_BIG_ORDER));
  endproperty
  a_order_capture: assert property (p_order_capture) else $error("byte order not captured"); // R4

  // Boot decode against the captured strap
  property p_boot_emul;
    @(posedge ref_clk) disable iff (!nrst)
      (st.bootSel == `BSIRQ_BOOT_EMUL) |-> emulBoot && !romBoot && !bootFault;
  endproperty
  a_boot_emul: assert property (p_boot_emul) else $error("emulation boot decode wrong"); // R1

  property p_boot_rom8;
    @(posedge ref_clk) disable iff (!nrst)
      (st.bootSel == `BSIRQ_BOOT_ROM8) |-> romBoot && !romWidth16 && !emulBoot;
  endproperty
  a_boot_rom8: assert property (p_boot_rom8) else $error("8-bit boot decode wrong"); // R2

  property p_boot_rom16;
    @(posedge ref_clk) disable iff (!nrst)
      (st.bootSel == `BSIRQ_BOOT_ROM16) |-> romBoot && romWidth16 && !bootFault;
  endproperty
  a_boot_rom16: assert property (p_boot_rom16) else $error("16-bit boot decode wrong"); // R3

  // Byte order decode against the captured strap
  property p_big_order;
    @(posedge ref_clk) disable iff (!nrst)
      !st.inReset |-> (bigEndian == (st.byteOrder == `BSIRQ_BIG_ORDER));
  endproperty
  a_big_order: assert property (p_big_order) else $error("byte order decode wrong"); // R4

  // Non-maskable input: one pulse per rising edge and none otherwise
  property p_nmi_edge;
    @(posedge ref_clk) disable iff (!nrst)
      !st.inReset && $rose(nmiPin) |=> nmiEvent ##1 !nmiEvent;
  endproperty
  a_nmi_edge: assert property (p_nmi_edge) else $error("missed non-maskable edge"); // R7

  property p_nmi_quiet;
    @(posedge ref_clk) disable iff (!nrst)
      !$rose(nmiPin) |=> !nmiEvent;
  endproperty
  a_nmi_quiet: assert property (p_nmi_quiet) else $error("non-maskable pulse without edge"); // R7

  // Edge pins: lowest and highest pin, and silence while steady
  property p_irq0_edge;
    @(posedge ref_clk) disable iff (!nrst)
      !st.inReset && ((extIrqEdgePolarity[0] && $rose(extIrqPin[0])) ||
      (!extIrqEdgePolarity[0] && $fell(extIrqPin[0]))) |=> extIrqEvent[0];
  endproperty
  a_irq0_edge: assert property (p_irq0_edge) else $error("missed interrupt edge"); // R10

  property p_irq_top_edge;
    @(posedge ref_clk) disable iff (!nrst)
      !st.inReset && ((extIrqEdgePolarity[IRQ_PINS-1] && $rose(extIrqPin[IRQ_PINS-1])) ||
      (!extIrqEdgePolarity[IRQ_PINS-1] && $fell(extIrqPin[IRQ_PINS-1]))) |=> extIrqEvent[IRQ_PINS-1];
  endproperty
  a_irq_top_edge: assert property (p_irq_top_edge) else $error("missed top interrupt edge"); // R10

  property p_irq_quiet;
    @(posedge ref_clk) disable iff (!nrst)
      $stable(extIrqPin) |=> (extIrqEvent == '0);
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt without edge"); // R9

  // Debug mode decode, one cycle behind the select pins
  property p_dbg_decode;
    @(posedge ref_clk) disable iff (!nrst)
      (st.dbgMode != `BSIRQ_DBG_SCAN) && (st.dbgMode != `BSIRQ_DBG_EMUL) |->
        dbgFault && !scanMode && !emulMode;
  endproperty
  a_dbg_decode: assert property (p_dbg_decode) else $error("debug mode decode wrong"); // R11

  property p_dbg_scan;
    @(posedge ref_clk) disable iff (!nrst)
      (debugModeSelect == `BSIRQ_DBG_SCAN) |=> scanMode && !emulMode && !dbgFault;
  endproperty
  a_dbg_scan: assert property (p_dbg_scan) else $error("scan mode decode wrong"); // R11

  property p_dbg_emul;
    @(posedge ref_clk) disable iff (!nrst)
      (debugModeSelect == `BSIRQ_DBG_EMUL) |=> emulMode && !scanMode && !dbgFault;
  endproperty
  a_dbg_emul: assert property (p_dbg_emul) else $error("emulation mode decode wrong"); // R11

endmodule // bsirq_core
`default_nettype wire

//--- core/bsirq_pkg.sv
/*
  Types of the strap and external interrupt block.
  Assumes the constants header is on the include path.
*/
`include "bsirq_regs.svh"

package bsirq_pkg;

  // Decoded boot source
  typedef enum logic [1:0] {
    BSIRQ_BOOT_EMULATION,
    BSIRQ_BOOT_ROM_8BIT,
    BSIRQ_BOOT_ROM_16BIT,
    BSIRQ_BOOT_RESERVED
  } bsirq_boot_e;

  // Whole state of the block
  typedef struct packed {
    logic                         inReset;
    logic [1:0]                   bootSel;
    logic                         byteOrder;
    logic                         orderFix;
    logic [1:0]                   dbgMode;
    logic                         nmiLast;
    logic                         nmiPulse;
    logic [`BSIRQ_IRQ_PINS-1:0]   irqLast;
    logic [`BSIRQ_IRQ_PINS-1:0]   irqPulse;
    logic                         romBoot;
    logic                         emulBoot;
    logic                         romWidth16;
    logic                         bootFault;
    logic                         bigEndian;
    logic                         orderFault;
    logic                         scanMode;
    logic                         emulMode;
    logic                         dbgFault;
  } bsirq_state_s;

endpackage : bsirq_pkg

//--- core/bsirq_regs.svh
/*
  Constants of the strap and external interrupt block: strap encodings,
  debug mode encodings and pin counts.
  Assumes inclusion by bare name from the package and design file.
*/
`ifndef BSIRQ_REGS_SVH
`define BSIRQ_REGS_SVH

// Boot source encodings
`define BSIRQ_BOOT_EMUL    2'h0
`define BSIRQ_BOOT_ROM8    2'h1
`define BSIRQ_BOOT_ROM16   2'h2
`define BSIRQ_BOOT_RSVD    2'h3
// Debug mode encodings
`define BSIRQ_DBG_SCAN     2'h0
`define BSIRQ_DBG_EMUL     2'h3
// Byte order level that selects big-endian
`define BSIRQ_BIG_ORDER    1'h0
// Number of edge interrupt pins
`define BSIRQ_IRQ_PINS     4
// Reset values of captured straps
`define BSIRQ_RST_BOOT     2'h1
`define BSIRQ_RST_ORDER    1'h1
`define BSIRQ_RST_FIX      1'h1
// External bus width codes
`define BSIRQ_WIDTH8       1'h0
`define BSIRQ_WIDTH16      1'h1

`endif

//--- tb/bsirq_board.sv
/*
  Board model: configuration straps and interrupt sources.
  Assumes the bench asks for strap and pin levels at each clock edge.
*/
`timescale 1ns/100ps
`default_nettype none
module bsirq_board (
  // Clock
  input  wire logic       ref_clk,
  // Requests from the bench
  input  wire logic [1:0] wantBoot,
  input  wire logic       wantOrder,
  input  wire logic [4:0] wantPins,
  // Pins toward the device
  output var  logic [1:0] bootSelect        = 2'h1,
  output var  logic       byteOrderSelect   = 1'h1,
  output var  logic       extBusBigOrderFix = 1'h1,
  output var  logic       nmiPin            = 1'h0,
  output var  logic [3:0] extIrqPin         = 4'h0
);
  // Pins move just after the edge
  always @(posedge ref_clk) begin
    bootSelect <= (wantBoot == 2'h3) ? 2'h1 : wantBoot;
    byteOrderSelect <= wantOrder;
    extBusBigOrderFix <= wantOrder;
    nmiPin <= wantPins[4];
    extIrqPin <= wantPins[3:0];
  end
endmodule // bsirq_board
`default_nettype wire

//--- tb/tb_top.sv
/*
  Bench: strap sweep over resets, debug decode, random interrupt traffic.
  Assumes the board model and the design package are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`include "bsirq_regs.svh"
module tb_top;
  logic       ref_clk = 1'b0;
  logic       nrst    = 1'b0;
  logic       evOn    = 1'b0;
  logic [1:0] wantBoot = 2'h1;
  logic [1:0] dbg      = 2'h3;
  logic       wantOrder = 1'h1;
  logic [4:0] wantPins = 5'h00;
  logic [4:0] h1       = 5'h00;
  logic [4:0] h2       = 5'h00;
  logic [3:0] pol      = 4'hF;
  logic [3:0] pol1     = 4'hF;
  logic [3:0] extIrqPin, extIrqEvent;
  logic [1:0] bootSelect, bootSource;
  logic       byteOrderSelect, extBusBigOrderFix, nmiPin, nmiEvent;
  logic       romBoot, emulBoot, romWidth16, bootFault, bigEndian, orderFault, scanMode, emulMode, dbgFault;
  int         failCount = 0;
  int         samplesChecked = 0;
  int         seed = 73;

  bsirq_board brd (.ref_clk, .wantBoot, .wantOrder, .wantPins, .bootSelect, .byteOrderSelect,
                   .extBusBigOrderFix, .nmiPin, .extIrqPin);
  bsirq_core dut (.ref_clk, .nrst, .bootSelect, .byteOrderSelect, .extBusBigOrderFix,
                  .debugModeSelect(dbg), .nmiPin, .extIrqPin, .extIrqEdgePolarity(pol), .romBoot,
                  .emulBoot, .romWidth16, .bootFault, .bootSource, .bigEndian, .orderFault,
                  .scanMode, .emulMode, .dbgFault, .nmiEvent, .extIrqEvent);

  // Clock, 8 ns period
  initial forever #4 ref_clk = ~ref_clk;

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      failCount++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("Compared %0d, mismatched %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Expected boot decode, source and byte order
  function automatic logic [7:0] expBoot(input logic [1:0] b, input logic o);
    return {b == 2'h1 || b == 2'h2, b == 2'h0, b == 2'h2, b == 2'h3, b, ~o, 1'b0};
  endfunction

  // Expected edge events from the older and newer pin samples
  function automatic logic [7:0] expEvents(input logic [4:0] older, input logic [4:0] newer, input logic [3:0] p);
    return {3'h0, ~older[4] & newer[4], (p & ~older[3:0] & newer[3:0]) | (~p & older[3:0] & ~newer[3:0])};
  endfunction

  // Edge events expected from two earlier pin samples
  always @(posedge ref_clk) begin
    if (evOn) begin
      check({3'h0, nmiEvent, extIrqEvent}, expEvents(h2, h1, pol1));
    end
    h2 = h1;
    h1 = {nmiPin, extIrqPin};
    pol1 = pol;
  end

  // Watchdog
  initial begin
    repeat (5000) @(posedge ref_clk);
    failCount++;
    results();
  end

  // Main sequence
  initial begin
    for (int b = 0; b < 6; b++) begin
      nrst <= 1'b0;
      wantBoot <= 2'(b / 2);
      wantOrder <= b[0];
      repeat (8) @(posedge ref_clk);
      nrst <= 1'b1;
      @(posedge ref_clk);
      wantBoot <= 2'(2 - b / 2);
      wantOrder <= ~b[0];
      repeat (4) @(posedge ref_clk);
      check({romBoot, emulBoot, romWidth16, bootFault, bootSource, bigEndian, orderFault},
            expBoot(2'(b / 2), b[0]));
    end
    for (int d = 0; d < 4; d++) begin
      dbg <= 2'(d);
      repeat (3) @(posedge ref_clk);
      check({5'h0, scanMode, emulMode, dbgFault}, {5'h0, d == 0, d == 3, d == 1 || d == 2});
    end
    // Boundary scan entry: debug selects and reset driven low together
    dbg  <= `BSIRQ_DBG_SCAN;
    nrst <= 1'b0;
    repeat (8) @(posedge ref_clk);
    check({romBoot, emulBoot, romWidth16, bootFault, bootSource, bigEndian, orderFault},
          expBoot(`BSIRQ_RST_BOOT, `BSIRQ_RST_ORDER));
    check({5'h0, scanMode, emulMode, dbgFault}, 8'h02);
    nrst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    check({5'h0, scanMode, emulMode, dbgFault}, 8'h04);
    evOn <= 1'b1;
    repeat (2000) begin
      @(posedge ref_clk);
      wantPins <= 5'($random(seed));
      if ($random(seed) % 16 == 0) begin
        pol <= 4'($random(seed));
      end
    end
    // All pins high together, then polarity flipped while steady
    wantPins <= 5'h1F;
    repeat (4) @(posedge ref_clk);
    pol <= ~pol;
    repeat (4) @(posedge ref_clk);
    results();
  end
endmodule // tb_top
`default_nettype wire
